// >>> hdl/period_timer_pkg.sv
package period_timer_pkg;

  // ---------------------------------------------------------------
  // Register map, byte addresses on the AXI4-Lite slave
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_COUNT   = 4'h0;
  localparam logic [3:0] ADDR_LIMIT   = 4'h4;
  localparam logic [3:0] ADDR_CONTROL = 4'h8;
  localparam logic [3:0] ADDR_FLAGS   = 4'hc;
  localparam logic [3:0] ADDR_ENABLES = 4'h0;
  localparam logic [3:0] ADDR_PRIO    = 4'h4;
  localparam logic [1:0] PAGE_TIMER   = 2'h0;
  localparam logic [1:0] PAGE_IRQ     = 2'h1;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int         CTL_IN_DIV_LSB    = 0;
  localparam int         CTL_RUN_BIT       = 2;
  localparam int         CTL_MATCH_DIV_LSB = 3;
  localparam int         IRQ_MATCH_BIT     = 1;
  localparam logic [7:0] CTL_WRITE_MASK    = 8'h7f;
  localparam logic [7:0] RESET_COUNT       = 8'h00;
  localparam logic [7:0] RESET_LIMIT       = 8'hff;
  localparam logic [7:0] RESET_CONTROL     = 8'h00;
  localparam logic [7:0] RESET_IRQ         = 8'h00;

  // ---------------------------------------------------------------
  // Prescaler terminal counts
  // ---------------------------------------------------------------
  localparam logic [3:0] PRE_TERM_1  = 4'h0;
  localparam logic [3:0] PRE_TERM_4  = 4'h3;
  localparam logic [3:0] PRE_TERM_16 = 4'hf;

  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_RESP = 2'b10
  } bus_state_t;

endpackage

// >>> hdl/match_postscaler.sv
`timescale 1ns/100ps
// Counts period matches and pulses done when the selected count completes.
module match_postscaler
  import period_timer_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clear,
  input  wire logic       match,
  input  wire logic [3:0] select,
  output logic            done
);
  logic [3:0] count;

  always_ff @(posedge clk) begin
    if (!rst_n || clear) begin
      count <= 4'h0;
    end else if (match) begin
      if (count >= select) begin
        count <= 4'h0;
      end else begin
        count <= count + 4'h1;
      end
    end
  end

  // Done is combinational so the flag sets in the same cycle as the match.
  assign done = match && !clear && (count >= select);

endmodule

// >>> hdl/period_match_timer8.sv
`timescale 1ns/100ps
// Overview of operation
// - Instruction clock through 1, 4, 16 prescaler
// - Prescale field 00 /1, 01 /4, 1x /16
// - Count up, clear after matching limit
// - Limit register read/write, resets to FFh
// - Postscaler 1 to 16 sets match flag
// - Postscale field n divides by n+1
// - Control bit 2 runs or stops timer
// - Count/control write or reset clears scalers
// - Control write keeps count value
// - Count register read/write, reset to zero
// - Pre-postscaler match output to serial port
// - Count and match usable as PWM base
// - Flag, enable, priority at bit 1
// - Control bit 7 reads zero, resets zero
module period_match_timer8
  import period_timer_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        instr_tick,
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             period_match,
  output logic [7:0]       pwm_count,
  output logic             irq,
  output logic             irq_high_priority
);

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [7:0] period_timer_count;
  logic [7:0] period_timer_limit;
  logic [7:0] period_timer_control;
  logic [7:0] peripheral_irq_flags_1;
  logic [7:0] peripheral_irq_enables_1;
  logic [7:0] peripheral_irq_priority_1;
  logic [3:0] pre_count;
  logic [3:0] pre_term;
  logic       inc;
  logic       match_now;
  logic       post_done;
  logic       scaler_clear;

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  bus_state_t wr_state;
  bus_state_t rd_state;
  logic [4:0] aw_addr;
  logic       aw_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_held;
  logic        wr_fire;
  logic        wr_ok;
  logic        rd_fire;

  function automatic logic addr_hit(input logic [4:0] a, input logic [1:0] page,
                                    input logic [3:0] off);
    addr_hit = (a[4] == page[0]) && (a[3:0] == off);
  endfunction

  assign s_axi_awready = (wr_state == BUS_IDLE) && !aw_held;
  assign s_axi_wready  = (wr_state == BUS_IDLE) && !w_held;
  assign s_axi_arready = (rd_state == BUS_IDLE);
  assign wr_fire = (wr_state == BUS_IDLE) && aw_held && w_held;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign wr_ok   = wr_fire && w_strb[0];

  logic wr_count;
  logic wr_limit;
  logic wr_control;
  logic wr_flags;
  logic wr_enables;
  logic wr_prio;
  assign wr_count   = wr_ok && addr_hit(aw_addr, PAGE_TIMER, ADDR_COUNT);
  assign wr_limit   = wr_ok && addr_hit(aw_addr, PAGE_TIMER, ADDR_LIMIT);
  assign wr_control = wr_ok && addr_hit(aw_addr, PAGE_TIMER, ADDR_CONTROL);
  assign wr_flags   = wr_ok && addr_hit(aw_addr, PAGE_TIMER, ADDR_FLAGS);
  assign wr_enables = wr_ok && addr_hit(aw_addr, PAGE_IRQ, ADDR_ENABLES);
  assign wr_prio    = wr_ok && addr_hit(aw_addr, PAGE_IRQ, ADDR_PRIO);

  logic wr_mapped;
  assign wr_mapped = addr_hit(aw_addr, PAGE_TIMER, ADDR_COUNT)
                  || addr_hit(aw_addr, PAGE_TIMER, ADDR_LIMIT)
                  || addr_hit(aw_addr, PAGE_TIMER, ADDR_CONTROL)
                  || addr_hit(aw_addr, PAGE_TIMER, ADDR_FLAGS)
                  || addr_hit(aw_addr, PAGE_IRQ, ADDR_ENABLES)
                  || addr_hit(aw_addr, PAGE_IRQ, ADDR_PRIO);

  // Address and data are captured independently, so either may come first.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      aw_addr <= 5'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_state    <= BUS_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= AXI_OKAY;
    end else begin
      case (wr_state)
        BUS_IDLE: begin
          if (wr_fire) begin
            wr_state     <= BUS_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? AXI_OKAY : AXI_SLVERR;
          end
        end
        BUS_RESP: begin
          if (s_axi_bready) begin
            wr_state     <= BUS_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wr_state     <= BUS_IDLE;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_state     <= BUS_IDLE;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= AXI_OKAY;
    end else begin
      case (rd_state)
        BUS_IDLE: begin
          if (rd_fire) begin
            rd_state     <= BUS_RESP;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= AXI_OKAY;
            if (addr_hit(s_axi_araddr, PAGE_TIMER, ADDR_COUNT)) begin
              s_axi_rdata <= {24'h000000, period_timer_count};
            end else if (addr_hit(s_axi_araddr, PAGE_TIMER, ADDR_LIMIT)) begin
              s_axi_rdata <= {24'h000000, period_timer_limit};
            end else if (addr_hit(s_axi_araddr, PAGE_TIMER, ADDR_CONTROL)) begin
              s_axi_rdata <= {24'h000000, period_timer_control & CTL_WRITE_MASK};
            end else if (addr_hit(s_axi_araddr, PAGE_TIMER, ADDR_FLAGS)) begin
              s_axi_rdata <= {24'h000000, peripheral_irq_flags_1};
            end else if (addr_hit(s_axi_araddr, PAGE_IRQ, ADDR_ENABLES)) begin
              s_axi_rdata <= {24'h000000, peripheral_irq_enables_1};
            end else if (addr_hit(s_axi_araddr, PAGE_IRQ, ADDR_PRIO)) begin
              s_axi_rdata <= {24'h000000, peripheral_irq_priority_1};
            end else begin
              s_axi_rdata <= 32'h0000_0000;
              s_axi_rresp <= AXI_SLVERR;
            end
          end
        end
        BUS_RESP: begin
          if (s_axi_rready) begin
            rd_state     <= BUS_IDLE;
            s_axi_rvalid <= 1'b0;
          end
        end
        default: begin
          rd_state     <= BUS_IDLE;
          s_axi_rvalid <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Control and limit registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      period_timer_control <= RESET_CONTROL;
    end else if (wr_control) begin
      period_timer_control <= w_data[7:0] & CTL_WRITE_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      period_timer_limit <= RESET_LIMIT;
    end else if (wr_limit) begin
      period_timer_limit <= w_data[7:0];
    end
  end

  // ---------------------------------------------------------------
  // Prescaler and count
  // ---------------------------------------------------------------
  logic [1:0] in_div;
  logic       running;
  assign in_div  = period_timer_control[CTL_IN_DIV_LSB +: 2];
  assign running = period_timer_control[CTL_RUN_BIT];

  always_comb begin
    case (in_div)
      2'b00:   pre_term = PRE_TERM_1;
      2'b01:   pre_term = PRE_TERM_4;
      default: pre_term = PRE_TERM_16;
    endcase
  end

  assign scaler_clear = wr_count || wr_control;

  // A stopped timer ignores ticks entirely, so all scaler state freezes.
  always_ff @(posedge clk) begin
    if (!rst_n || scaler_clear) begin
      pre_count <= 4'h0;
    end else if (running && instr_tick) begin
      pre_count <= (pre_count >= pre_term) ? 4'h0 : pre_count + 4'h1;
    end
  end

  assign inc       = running && instr_tick && !scaler_clear && (pre_count >= pre_term);
  assign match_now = inc && (period_timer_count == period_timer_limit);

  // A count write wins over an increment in the same cycle. Control writes are
  // deliberately absent here, so they leave the count as it stands.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      period_timer_count <= RESET_COUNT;
    end else if (wr_count) begin
      period_timer_count <= w_data[7:0];
    end else if (match_now) begin
      period_timer_count <= 8'h00;
    end else if (inc) begin
      period_timer_count <= period_timer_count + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      period_match <= 1'b0;
    end else begin
      period_match <= match_now;
    end
  end

  assign pwm_count = period_timer_count;

  match_postscaler match_postscaler_inst (
    .clk    (clk),
    .rst_n  (rst_n),
    .clear  (scaler_clear),
    .match  (match_now),
    .select (period_timer_control[CTL_MATCH_DIV_LSB +: 4]),
    .done   (post_done)
  );

  // ---------------------------------------------------------------
  // Interrupt registers
  // ---------------------------------------------------------------
  // Only the timer's own bit is implemented; the others read zero, which also
  // keeps the parallel slave bits clear.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      peripheral_irq_flags_1 <= RESET_IRQ;
    end else if (post_done) begin
      peripheral_irq_flags_1[IRQ_MATCH_BIT] <= 1'b1;
    end else if (wr_flags && w_data[IRQ_MATCH_BIT]) begin
      peripheral_irq_flags_1[IRQ_MATCH_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      peripheral_irq_enables_1  <= RESET_IRQ;
      peripheral_irq_priority_1 <= RESET_IRQ;
    end else begin
      if (wr_enables) begin
        peripheral_irq_enables_1[IRQ_MATCH_BIT] <= w_data[IRQ_MATCH_BIT];
      end
      if (wr_prio) begin
        peripheral_irq_priority_1[IRQ_MATCH_BIT] <= w_data[IRQ_MATCH_BIT];
      end
    end
  end

  logic pending;
  assign pending           = |(peripheral_irq_flags_1 & peripheral_irq_enables_1);
  assign irq               = pending;
  assign irq_high_priority = |(peripheral_irq_flags_1 & peripheral_irq_enables_1
                               & peripheral_irq_priority_1);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_match_clears: assert property (@(posedge clk) disable iff (!rst_n)
    match_now && !wr_count |=> period_timer_count == 8'h00)
    else $error("count did not clear after match");
  a_count_steps: assert property (@(posedge clk) disable iff (!rst_n)
    inc && !match_now && !wr_count |=> period_timer_count == $past(period_timer_count) + 8'h01)
    else $error("count did not step by one");
  a_stop_holds: assert property (@(posedge clk) disable iff (!rst_n)
    !running && !wr_count |=> $stable(period_timer_count))
    else $error("stopped timer changed count");
  a_ctl_keeps: assert property (@(posedge clk) disable iff (!rst_n)
    wr_control && !inc |=> $stable(period_timer_count))
    else $error("control write changed count");
  a_pre_clear: assert property (@(posedge clk) disable iff (!rst_n)
    scaler_clear |=> pre_count == 4'h0)
    else $error("prescaler not cleared");
  a_div1_each: assert property (@(posedge clk) disable iff (!rst_n)
    running && instr_tick && in_div == 2'b00 && !scaler_clear |-> inc)
    else $error("divide by one missed a tick");
  a_flag_sets: assert property (@(posedge clk) disable iff (!rst_n)
    post_done |=> peripheral_irq_flags_1[IRQ_MATCH_BIT])
    else $error("flag not set on postscaler done");
  a_bit7_zero: assert property (@(posedge clk) disable iff (!rst_n)
    period_timer_control[7] == 1'b0)
    else $error("control bit 7 set");
  a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
    irq == (peripheral_irq_flags_1[IRQ_MATCH_BIT] && peripheral_irq_enables_1[IRQ_MATCH_BIT]))
    else $error("irq does not follow flag and enable");
  a_match_out: assert property (@(posedge clk) disable iff (!rst_n)
    match_now |=> period_match)
    else $error("match output missing");

endmodule

// >>> sim/serial_port_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Far-side consumer of the match strobe and the count
// ------------------------------------------------------------
module serial_port_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       period_match,
  input  wire logic [7:0] pwm_count,
  input  wire logic       clear_stats,
  output int              match_total,
  output int              last_gap,
  output logic [7:0]      peak
);
  int gap;

  // The serial port sees only the strobe, so the gap between strobes is its shift period.
  always_ff @(posedge clk) begin
    if (!rst_n || clear_stats) begin
      match_total <= 0;
      last_gap    <= 0;
      gap         <= 0;
    end else if (period_match) begin
      match_total <= match_total + 1;
      last_gap    <= gap + 1;
      gap         <= 0;
    end else begin
      gap <= gap + 1;
    end
  end

  // A PWM time base needs the highest count reached, kept here since reset or the last clear_stats.
  always_ff @(posedge clk) begin
    if (!rst_n || clear_stats) begin
      peak <= 8'h00;
    end else if (pwm_count > peak) begin
      peak <= pwm_count;
    end
  end
endmodule

// >>> sim/test_period_match_timer8.sv
`timescale 1ns/100ps
module test_period_match_timer8 import period_timer_pkg::*;;
  localparam logic [4:0] A_CNT = 5'h00, A_LIM = 5'h04, A_CTL = 5'h08;
  localparam logic [4:0] A_FLG = 5'h0c, A_ENA = 5'h10, A_PRI = 5'h14;
  logic        clk, rst_n, instr_tick, clear_stats;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        period_match, irq, irq_hp;
  logic [7:0]  pwm_count, peak;
  int          match_total, last_gap, failures, samples_checked;

  period_match_timer8 period_match_timer8_inst (.clk(clk), .rst_n(rst_n),
    .instr_tick(instr_tick), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .period_match(period_match), .pwm_count(pwm_count), .irq(irq),
    .irq_high_priority(irq_hp));

  serial_port_model serial_port_model_inst (.clk(clk), .rst_n(rst_n),
    .period_match(period_match), .pwm_count(pwm_count), .clear_stats(clear_stats),
    .match_total(match_total), .last_gap(last_gap), .peak(peak));

  // ------------------------------------------------------------
  // Checking, bus and wait helpers
  // ------------------------------------------------------------
  task automatic results();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic hang();
    failures++;
    $display("BAD %0t wait ran out", $time);
    results();
  endtask

  // Ready and valid are looked at mid-cycle, where they already hold the value
  // that the next rising edge samples; reading them at the edge would race.
  task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    int   n;
    logic a_on, w_on, a_hit, w_hit, b_hit;
    n = 0;
    a_on = 1'b1;
    w_on = 1'b1;
    b_hit = 1'b0;
    r = 2'h0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_hit && n < 40) begin
      @(negedge clk);
      a_hit = a_on && (awready === 1'b1);
      w_hit = w_on && (wready === 1'b1);
      b_hit = (bvalid === 1'b1);
      r = bresp;
      @(posedge clk);
      n++;
      if (a_hit) begin
        a_on = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_hit) begin
        w_on = 1'b0;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b0;
    if (!b_hit) hang();
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    int   n;
    logic a_on, a_hit, r_hit;
    n = 0;
    a_on = 1'b1;
    r_hit = 1'b0;
    d = 32'h0000_0000;
    r = 2'h0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_hit && n < 40) begin
      @(negedge clk);
      a_hit = a_on && (arready === 1'b1);
      r_hit = (rvalid === 1'b1);
      d = rdata;
      r = rresp;
      @(posedge clk);
      n++;
      if (a_hit) begin
        a_on = 1'b0;
        arvalid <= 1'b0;
      end
    end
    rready <= 1'b0;
    if (!r_hit) hang();
  endtask

  task automatic wait_pulses(input int k);
    int start, n;
    start = match_total;
    n = 0;
    while (match_total < start + k && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 3000) hang();
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic s_reset_values();
    logic [4:0]  adr [6] = '{A_CNT, A_LIM, A_CTL, A_FLG, A_ENA, A_PRI};
    logic [7:0]  exp [6] = '{RESET_COUNT, RESET_LIMIT, RESET_CONTROL, 8'h00, 8'h00, 8'h00};
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 6; i++) begin
      rd(adr[i], d, r);
      check(d, {24'h0, exp[i]});
    end
    rd(5'h18, d, r);
    check({d[29:0], r}, {30'h0, AXI_SLVERR});
    wr(5'h1c, 32'h1, r);
    check(r, AXI_SLVERR);
    wr(A_LIM, 32'h5a, r);
    rd(A_LIM, d, r);
    check(d, 32'h5a);
    wr(A_CTL, 32'hff, r);
    rd(A_CTL, d, r);
    check(d, 32'h7f);
  endtask

  task automatic s_period();
    int          dv [4] = '{1, 4, 16, 16};
    logic [1:0]  r;
    wr(A_CTL, 32'h0, r);
    wr(A_LIM, 32'h3, r);
    wr(A_CNT, 32'h0, r);
    clear_stats <= 1'b1;
    @(posedge clk);
    clear_stats <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      wr(A_CTL, 32'h4 | i, r);
      wait_pulses(3);
      check(last_gap, 4 * dv[i]);
    end
    check(peak, 32'h3);
    wr(A_CTL, 32'h4, r);
    wr(A_LIM, 32'h7, r);
    wait_pulses(3);
    check(last_gap, 8);
  endtask

  task automatic s_stop();
    logic [31:0] c1, c2;
    logic [1:0]  r;
    wr(A_LIM, 32'hff, r);
    repeat (10) @(posedge clk);
    wr(A_CTL, 32'h0, r);
    rd(A_CNT, c1, r);
    repeat (20) @(posedge clk);
    rd(A_CNT, c2, r);
    check(c2, c1);
  endtask

  // Writes closer together than one prescaled tick must keep the count frozen.
  task automatic s_scaler_clear();
    logic [31:0] d;
    logic [1:0]  r;
    wr(A_CTL, 32'h6, r);
    repeat (6) wr(A_CNT, 32'h40, r);
    rd(A_CNT, d, r);
    check(d, 32'h40);
    repeat (6) wr(A_CTL, 32'h6, r);
    rd(A_CNT, d, r);
    check(d, 32'h40);
  endtask

  task automatic s_postscale(input logic [3:0] n);
    int          p, k;
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge clk);
    instr_tick <= 1'b0;
    wr(A_CTL, 32'h0, r);
    wr(A_FLG, 32'h2, r);
    wr(A_LIM, 32'h1, r);
    wr(A_CNT, 32'h0, r);
    wr(A_ENA, 32'h2, r);
    wr(A_PRI, 32'h2, r);
    wr(A_CTL, {25'h0, n, 3'h4}, r);
    instr_tick <= 1'b1;
    p = 0;
    k = 0;
    while (irq !== 1'b1 && k < 200) begin
      @(negedge clk);
      k++;
      if (period_match === 1'b1) p++;
    end
    @(negedge clk);
    if (period_match === 1'b1) p++;
    @(posedge clk);
    instr_tick <= 1'b0;
    if (k >= 200) hang();
    check(p, n + 1);
    check(irq_hp, 1'b1);
    wr(A_ENA, 32'h0, r);
    check(irq, 1'b0);
    rd(A_FLG, d, r);
    check(d, 32'h2);
    wr(A_FLG, 32'h2, r);
    rd(A_FLG, d, r);
    check(d, 32'h0);
    instr_tick <= 1'b1;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    rst_n = 1'b0; instr_tick = 1'b1; clear_stats = 1'b0; wdata = '0; wstrb = '0;
    awaddr = '0; araddr = '0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; failures = 0; samples_checked = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    s_reset_values();
    s_period();
    s_stop();
    s_scaler_clear();
    s_postscale(4'h0);
    s_postscale(4'h4);
    s_postscale(4'hf);
    results();
  end
endmodule
